// *** rtl/dgc_engine.sv ***
// digital gain curve engine: profiles, curve banks and gain stepping
`timescale 1ns/1ps
`include "dgc_regs.svh"
module dgc_engine import dgc_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // serial programming pins
    input wire logic serial_clk,
    input wire logic serial_enable_n,
    input wire logic serial_data_in,
    // gain control pins
    input wire logic gain_step_strobe,
    input wire logic gain_direction_in,
    // gain outputs, gain is 6 dB plus gain_fine eighths of a dB
    output logic [8:0] gain_fine,
    output logic [6:0] atten_level,
    output logic fixed_atten_active,
    output logic [15:0] curve_word,
    output logic [7:0] curve_row
);

    // ---------------------------------------------------------------
    // serial port
    // ---------------------------------------------------------------
    dgc_wr_t wr;

    dgc_spi u_spi (
        .clock(clock),
        .rst_b(rst_b),
        .serial_clk(serial_clk),
        .serial_enable_n(serial_enable_n),
        .serial_data_in(serial_data_in),
        .wr(wr)
    );

    // ---------------------------------------------------------------
    // profile registers
    // ---------------------------------------------------------------
    logic [15:0] limits [0:3];
    logic [15:0] steps [0:3];
    logic [7:0] atten_reg [0:3];
    logic [7:0] ctrl;
    dgc_profile_t prof [0:3];

    wire [7:0] lim_off [0:3] = '{`DGC_LIMITS_P0, `DGC_LIMITS_P1,
                                 `DGC_LIMITS_P2, `DGC_LIMITS_P3};
    wire [7:0] stp_off [0:3] = '{`DGC_STEPS_P0, `DGC_STEPS_P1,
                                 `DGC_STEPS_P2, `DGC_STEPS_P3};
    wire hit_a01 = wr.valid && wr.addr == `DGC_ATTEN_P01;
    wire hit_a23 = wr.valid && wr.addr == `DGC_ATTEN_P23;
    wire hit_ctrl = wr.valid && wr.addr == `DGC_CTRL;

    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_prof
            wire hit_lim = wr.valid && wr.addr == lim_off[p];
            wire hit_stp = wr.valid && wr.addr == stp_off[p];
            // even profiles sit in the high byte of the shared register
            wire hit_att = (p < 2) ? hit_a01 : hit_a23;
            wire [7:0] att_byte = (p % 2 == 0) ? wr.data[`DGC_HI_BYTE]
                                               : wr.data[`DGC_LO_BYTE];

            always_ff @(posedge clock) begin
                if (!rst_b) begin
                    limits[p] <= `DGC_LIMITS_RST;
                    steps[p] <= `DGC_STEPS_RST;
                    atten_reg[p] <= `DGC_ATTEN_RST;
                end else begin
                    if (hit_lim) begin
                        limits[p] <= wr.data;
                    end
                    if (hit_stp) begin
                        steps[p] <= wr.data;
                    end
                    if (hit_att) begin
                        atten_reg[p] <= att_byte;
                    end
                end
            end

            assign prof[p].start_gain = limits[p][`DGC_HI_BYTE];
            assign prof[p].stop_gain = limits[p][`DGC_LO_BYTE];
            assign prof[p].rise_step = steps[p][`DGC_HI_BYTE];
            assign prof[p].fall_step_size = steps[p][`DGC_LO_BYTE];
            assign prof[p].fixed_atten_enable_bit =
                atten_reg[p][`DGC_FIX_BIT];
            assign prof[p].atten = atten_reg[p][`DGC_ATTEN_FIELD];
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl <= `DGC_CTRL_RST;
        end else if (hit_ctrl) begin
            ctrl <= wr.data[`DGC_LO_BYTE];
        end
    end

    // ---------------------------------------------------------------
    // mode and profile selection
    // ---------------------------------------------------------------
    dgc_mode_t mode;
    dgc_mode_t mode_q;
    wire [1:0] prof_sel = ctrl[`DGC_CTRL_PROF];
    wire [1:0] bank_sel = ctrl[`DGC_CTRL_BANK];
    // the profile is read straight from the register, so it acts at once
    wire dgc_profile_t act = prof[prof_sel];

    assign mode = (ctrl[`DGC_CTRL_MODE] == 2'h0) ? DGC_MODE_EXT :
                  (ctrl[`DGC_CTRL_MODE] == 2'h1) ? DGC_MODE_INT :
                  DGC_MODE_OFF;
    wire ext_mode = mode == DGC_MODE_EXT;
    wire int_mode = mode == DGC_MODE_INT;
    wire mode_entry = mode != mode_q;
    wire ext_entry = mode_entry && ext_mode;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mode_q <= DGC_MODE_EXT;
        end else begin
            mode_q <= mode;
        end
    end

    // ---------------------------------------------------------------
    // strobe and direction synchronisers
    // ---------------------------------------------------------------
    // both pins share the same delay so direction lines up with its edge
    logic [1:0] stb_s;
    logic [1:0] dir_s;
    logic stb_d;
    wire step_edge = stb_s[1] & ~stb_d;
    wire dir_down = dir_s[1];

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stb_s <= 2'h0;
            dir_s <= 2'h0;
            stb_d <= 1'b0;
        end else begin
            stb_s <= {stb_s[0], gain_step_strobe};
            dir_s <= {dir_s[0], gain_direction_in};
            stb_d <= stb_s[1];
        end
    end

    // ---------------------------------------------------------------
    // gain stepping
    // ---------------------------------------------------------------
    // gain kept in eighths so odd step codes are not rounded away
    wire [8:0] start_fine = {act.start_gain, 1'b0};
    wire [9:0] up_sum = {1'b0, gain_fine} + {2'h0, act.rise_step} + 10'h001;
    wire [8:0] dn_step = {1'b0, act.fall_step_size} + 9'h001;
    wire [8:0] up_sat = (up_sum > {1'b0, `DGC_GAIN_MAX}) ? `DGC_GAIN_MAX
                        : up_sum[8:0];
    wire [8:0] dn_sat = (gain_fine < dn_step) ? 9'h000
                        : gain_fine - dn_step;
    wire [8:0] next_gain = ext_entry ? start_fine :
                           (ext_mode && step_edge) ?
                           (dir_down ? dn_sat : up_sat) :
                           gain_fine;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            gain_fine <= {8'(`DGC_LIMITS_RST >> 8), 1'b0};
        end else begin
            gain_fine <= next_gain;
        end
    end

    // ---------------------------------------------------------------
    // attenuator
    // ---------------------------------------------------------------
    // level is -8 dB plus atten_level eighths; zero code when not fixed
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            fixed_atten_active <= 1'b0;
            atten_level <= 7'h00;
        end else begin
            fixed_atten_active <= act.fixed_atten_enable_bit;
            atten_level <= act.fixed_atten_enable_bit ? act.atten
                           : 7'h00;
        end
    end

    // ---------------------------------------------------------------
    // curve memory banks
    // ---------------------------------------------------------------
    // host writes and engine reads use separate ports of each bank
    logic [15:0] bank_rd [0:3];
    logic rd_pend;
    wire mem_hit = wr.valid && wr.addr <= `DGC_ROW_LAST;
    wire curve_rd = int_mode && step_edge && !mode_entry;
    wire [7:0] next_row = (curve_row == `DGC_ROW_LAST) ? 8'h00
                          : curve_row + 8'h01;

    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_bank
            // write routed by bank select, read owned by its profile
            wire bank_we = mem_hit && bank_sel == b;
            wire bank_re = curve_rd && prof_sel == b;

            dgc_bank u_bank (
                .clock(clock),
                .we(bank_we),
                .waddr(wr.addr),
                .wdata(wr.data),
                .re(bank_re),
                .raddr(curve_row),
                .rdata(bank_rd[b])
            );
        end
    endgenerate

    // ramp sequencing of internal mode is left to the consumer of the word
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            curve_row <= 8'h00;
            rd_pend <= 1'b0;
            curve_word <= 16'h0000;
        end else begin
            rd_pend <= curve_rd;
            if (mode_entry) begin
                curve_row <= 8'h00;
            end else if (curve_rd) begin
                curve_row <= next_row;
            end
            if (rd_pend) begin
                curve_word <= bank_rd[prof_sel];
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_up_edge;
        ext_mode && !mode_entry && step_edge && !dir_down;
    endsequence

    sequence s_dn_edge;
        ext_mode && !mode_entry && step_edge && dir_down;
    endsequence

    AST_RESET_GAIN: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(rst_b) |-> gain_fine == 9'h000)
        else $error("gain not at start gain after reset");

    AST_REENTRY: assert property (@(posedge clock) disable iff (!rst_b)
        ext_entry |=> gain_fine == {$past(act.start_gain), 1'b0})
        else $error("gain not reloaded on external mode entry");

    AST_STEP_UP: assert property (@(posedge clock) disable iff (!rst_b)
        s_up_edge |=> gain_fine == $past(up_sat) &&
        gain_fine >= $past(gain_fine))
        else $error("rising step wrong");

    AST_STEP_DOWN: assert property (@(posedge clock) disable iff (!rst_b)
        s_dn_edge |=> gain_fine == (($past(gain_fine) < $past(dn_step)) ?
        9'h000 : $past(gain_fine) - $past(dn_step)))
        else $error("falling step wrong");

    AST_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
        !step_edge && !mode_entry |=> $stable(gain_fine))
        else $error("gain moved without a strobe edge");

    AST_RANGE: assert property (@(posedge clock) disable iff (!rst_b)
        gain_fine <= `DGC_GAIN_MAX)
        else $error("gain outside legal range");

    AST_BANK_ROUTE: assert property (@(posedge clock) disable iff (!rst_b)
        mem_hit |-> g_bank[0].bank_we + g_bank[1].bank_we +
        g_bank[2].bank_we + g_bank[3].bank_we == 1)
        else $error("memory write not routed to exactly one bank");

    AST_LIMITS_WR: assert property (@(posedge clock) disable iff (!rst_b)
        wr.valid && wr.addr == `DGC_LIMITS_P2 |=>
        limits[2] == $past(wr.data))
        else $error("profile register write lost");

    AST_ATTEN_FOLLOW: assert property (@(posedge clock) disable iff (!rst_b)
        act.fixed_atten_enable_bit ##1 $stable(ctrl) |->
        fixed_atten_active && atten_level == $past(act.atten))
        else $error("fixed attenuation not taken from active profile");

    AST_CURVE_READ: assert property (@(posedge clock) disable iff (!rst_b)
        curve_rd ##1 !mode_entry |=> curve_word == $past(bank_rd[prof_sel]))
        else $error("curve word not delivered two cycles after strobe");

    AST_RESET_OUTS: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(rst_b) |-> atten_level == 7'h00 && !fixed_atten_active &&
        curve_word == 16'h0000 && curve_row == 8'h00)
        else $error("outputs not cleared by reset");

    AST_EXT_ONLY: assert property (@(posedge clock) disable iff (!rst_b)
        !ext_mode |=> $stable(gain_fine))
        else $error("gain moved outside external mode");

    AST_ATTEN_OFF: assert property (@(posedge clock) disable iff (!rst_b)
        !act.fixed_atten_enable_bit |=> !fixed_atten_active &&
        atten_level == 7'h00)
        else $error("attenuation applied while fixed mode is off");

    AST_ROW_RANGE: assert property (@(posedge clock) disable iff (!rst_b)
        curve_row <= `DGC_ROW_LAST)
        else $error("curve row outside the bank");

    AST_ROW_STEP: assert property (@(posedge clock) disable iff (!rst_b)
        curve_rd |=> curve_row == (($past(curve_row) == `DGC_ROW_LAST) ?
        8'h00 : $past(curve_row) + 8'h01))
        else $error("curve row not advanced by one");

endmodule : dgc_engine

// *** include/dgc_regs.svh ***
// register offsets, field positions, reset values and limits of the engine
`ifndef DGC_REGS_SVH
`define DGC_REGS_SVH

// ---------------------------------------------------------------
// register offsets (8-bit serial address space)
// ---------------------------------------------------------------
`define DGC_LIMITS_P0 8'ha1
`define DGC_LIMITS_P1 8'ha6
`define DGC_LIMITS_P2 8'hab
`define DGC_LIMITS_P3 8'hb0
`define DGC_STEPS_P0 8'ha2
`define DGC_STEPS_P1 8'ha7
`define DGC_STEPS_P2 8'hac
`define DGC_STEPS_P3 8'hb1
`define DGC_ATTEN_P01 8'hb9
`define DGC_ATTEN_P23 8'hba
`define DGC_CTRL 8'hbb
`define DGC_ROW_LAST 8'h9f

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DGC_HI_BYTE 15:8
`define DGC_LO_BYTE 7:0
`define DGC_FIX_BIT 7
`define DGC_ATTEN_FIELD 6:0
`define DGC_CTRL_MODE 1:0
`define DGC_CTRL_PROF 3:2
`define DGC_CTRL_BANK 5:4

// ---------------------------------------------------------------
// reset values and limits
// ---------------------------------------------------------------
`define DGC_LIMITS_RST 16'h009f
`define DGC_STEPS_RST 16'h00ff
`define DGC_ATTEN_RST 8'h00
`define DGC_CTRL_RST 8'h00
`define DGC_GAIN_MAX 9'h13e
`define DGC_MEM_ROWS 160
`define DGC_ADDR_BITS 8
`define DGC_DATA_BITS 16

`endif

// *** include/dgc_pkg.sv ***
// types shared by the gain curve engine files
package dgc_pkg;

    // one-hot gain mode of the engine
    typedef enum logic [2:0] {
        DGC_MODE_EXT = 3'b001,
        DGC_MODE_INT = 3'b010,
        DGC_MODE_OFF = 3'b100
    } dgc_mode_t;

    // one register write decoded from the serial port
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [15:0] data;
    } dgc_wr_t;

    // fields of one gain profile
    typedef struct packed {
        logic [7:0] start_gain;
        logic [7:0] stop_gain;
        logic [7:0] rise_step;
        logic [7:0] fall_step_size;
        logic fixed_atten_enable_bit;
        logic [6:0] atten;
    } dgc_profile_t;

endpackage : dgc_pkg

// *** rtl/dgc_bank.sv ***
// one gain curve memory bank, registered read port
`timescale 1ns/1ps
`include "dgc_regs.svh"
module dgc_bank import dgc_pkg::*; (
    // clock
    input wire logic clock,
    // write port
    input wire logic we,
    input wire logic [7:0] waddr,
    input wire logic [15:0] wdata,
    // read port
    input wire logic re,
    input wire logic [7:0] raddr,
    output logic [15:0] rdata
);

    logic [15:0] mem [0:`DGC_MEM_ROWS-1];

    // rows above the last are dropped, never aliased
    always_ff @(posedge clock) begin
        if (we && waddr <= `DGC_ROW_LAST) begin
            mem[waddr] <= wdata;
        end
        if (re && raddr <= `DGC_ROW_LAST) begin
            rdata <= mem[raddr];
        end
    end

endmodule : dgc_bank

// *** rtl/dgc_spi.sv ***
// serial programming port: address then 16-bit words, burst capable
`timescale 1ns/1ps
`include "dgc_regs.svh"
module dgc_spi import dgc_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // serial pins
    input wire logic serial_clk,
    input wire logic serial_enable_n,
    input wire logic serial_data_in,
    // decoded write, one-cycle valid
    output dgc_wr_t wr
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    // serial clock must stay below a sixth of clock so no edge is missed
    logic [1:0] sck_s;
    logic [1:0] sen_s;
    logic [1:0] sdi_s;
    logic sck_d;
    logic [4:0] bit_cnt;
    logic [14:0] shift;
    logic addr_done;
    logic [7:0] addr;
    logic [7:0] prev_addr;
    logic have_prev;
    wire sck_rise = sck_s[1] & ~sck_d;
    wire [4:0] last_bit = addr_done ? 5'h0f : 5'h07;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sck_s <= 2'h0;
            sen_s <= 2'h3;
            sdi_s <= 2'h0;
            sck_d <= 1'b0;
        end else begin
            sck_s <= {sck_s[0], serial_clk};
            sen_s <= {sen_s[0], serial_enable_n};
            sdi_s <= {sdi_s[0], serial_data_in};
            sck_d <= sck_s[1];
        end
    end

    // ---------------------------------------------------------------
    // frame decode
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            bit_cnt <= 5'h00;
            shift <= 15'h0000;
            addr_done <= 1'b0;
            addr <= 8'h00;
            wr <= '0;
        end else begin
            wr.valid <= 1'b0;
            if (sen_s[1]) begin
                bit_cnt <= 5'h00;
                addr_done <= 1'b0;
            end else if (sck_rise) begin
                shift <= {shift[13:0], sdi_s[1]};
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == last_bit) begin
                    bit_cnt <= 5'h00;
                    if (!addr_done) begin
                        addr <= {shift[6:0], sdi_s[1]};
                        addr_done <= 1'b1;
                    end else begin
                        wr.valid <= 1'b1;
                        wr.addr <= addr;
                        wr.data <= {shift, sdi_s[1]};
                        addr <= addr + 8'h01;
                    end
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b || sen_s[1]) begin
            have_prev <= 1'b0;
            prev_addr <= 8'h00;
        end else if (wr.valid) begin
            have_prev <= 1'b1;
            prev_addr <= wr.addr;
        end
    end

    AST_BURST_INCR: assert property (@(posedge clock) disable iff (!rst_b)
        wr.valid && have_prev |-> wr.addr == prev_addr + 8'h01)
        else $error("burst word not stored at next address");

endmodule : dgc_spi

// *** test/dgc_ctrl_model.sv ***
// controller model: serial host and gain pin driver
`timescale 1ns/1ps
module dgc_ctrl_model import dgc_pkg::*; (
    // clock
    input wire logic clock,
    // serial pins
    output logic serial_clk,
    output logic serial_enable_n,
    output logic serial_data_in,
    // gain pins
    output logic gain_step_strobe,
    output logic gain_direction_in
);
    initial begin
        serial_clk = 1'b0;
        serial_enable_n = 1'b1;
        serial_data_in = 1'b0;
        gain_step_strobe = 1'b0;
        gain_direction_in = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    // four clocks high and low: the pins pass two sync stages
    task automatic send_bit(input logic b);
        serial_data_in = b;
        tick(1);
        serial_clk = 1'b1;
        tick(4);
        serial_clk = 1'b0;
        tick(4);
    endtask : send_bit

    // address once, then words with enable held low; no reads ever
    task automatic write_burst(input logic [7:0] addr,
                               input logic [15:0] words [$]);
        serial_enable_n = 1'b0;
        tick(1);
        for (int i = 7; i >= 0; i--) send_bit(addr[i]);
        foreach (words[w]) begin
            for (int i = 15; i >= 0; i--) send_bit(words[w][i]);
        end
        serial_enable_n = 1'b1;
        // released line must not keep showing the last bit
        serial_data_in = ~serial_data_in;
        tick(8);
    endtask : write_burst

    // slow pulse keeps one rising edge per several sample clocks
    task automatic step(input logic down);
        gain_direction_in = down;
        tick(1);
        gain_step_strobe = 1'b1;
        tick(3);
        gain_step_strobe = 1'b0;
        tick(3);
    endtask : step
endmodule : dgc_ctrl_model

// *** test/dgc_engine_tb.sv ***
// self-checking bench of the gain curve engine
`timescale 1ns/1ps
`include "dgc_regs.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
    errors++; $display("Error at %0t: got %h want %h", $time, got, exp); \
    end end
module dgc_engine_tb import dgc_pkg::*;;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    wire serial_clk;
    wire serial_enable_n;
    wire serial_data_in;
    wire gain_step_strobe;
    wire gain_direction_in;
    wire [8:0] gain_fine;
    wire [6:0] atten_level;
    wire fixed_atten_active;
    wire [15:0] curve_word;
    wire [7:0] curve_row;
    logic [15:0] exp_words [3] = '{16'h1111, 16'h2222, 16'h3333};
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;

    always #12.5 clock = ~clock;

    dgc_engine uut (
        .clock(clock), .rst_b(rst_b), .serial_clk(serial_clk),
        .serial_enable_n(serial_enable_n), .serial_data_in(serial_data_in),
        .gain_step_strobe(gain_step_strobe),
        .gain_direction_in(gain_direction_in), .gain_fine(gain_fine),
        .atten_level(atten_level), .fixed_atten_active(fixed_atten_active),
        .curve_word(curve_word), .curve_row(curve_row)
    );

    dgc_ctrl_model host (
        .clock(clock), .serial_clk(serial_clk),
        .serial_enable_n(serial_enable_n), .serial_data_in(serial_data_in),
        .gain_step_strobe(gain_step_strobe),
        .gain_direction_in(gain_direction_in)
    );

    task automatic close_out();
        if (errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    task automatic wr(input logic [7:0] addr, input logic [15:0] data);
        host.write_burst(addr, '{data});
    endtask : wr

    // whole run needs about 7000 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            close_out();
        end
    end

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        #1;
        rst_b = 1'b1;
        `CHK(gain_fine, 9'h000)
        `CHK(atten_level, 7'h00)
        `CHK(fixed_atten_active, 1'b0)
        `CHK(curve_row, 8'h00)
        `CHK(curve_word, 16'h0000)
        wr(8'h00, 16'h4444);
        host.step(1'b0);
        `CHK(gain_fine, 9'h001)
        host.step(1'b1);
        `CHK(gain_fine, 9'h000)
        wr(`DGC_LIMITS_P0, 16'h0a9f);
        wr(`DGC_CTRL, 16'h0002);
        wr(`DGC_CTRL, 16'h0000);
        `CHK(gain_fine, 9'h014)
        wr(`DGC_STEPS_P0, 16'h0302);
        host.step(1'b0);
        `CHK(gain_fine, 9'h018)
        host.step(1'b1);
        `CHK(gain_fine, 9'h015)
        wr(`DGC_STEPS_P0, 16'hff00);
        host.step(1'b0);
        `CHK(gain_fine, 9'h115)
        host.step(1'b0);
        `CHK(gain_fine, `DGC_GAIN_MAX)
        // profile swap mid-curve keeps gain but swaps steps and attenuation
        wr(`DGC_STEPS_P1, 16'h0100);
        wr(`DGC_LIMITS_P1, 16'h3200);
        wr(`DGC_ATTEN_P01, 16'h05c0);
        wr(`DGC_CTRL, 16'h0004);
        `CHK(gain_fine, `DGC_GAIN_MAX)
        `CHK(fixed_atten_active, 1'b1)
        `CHK(atten_level, 7'h40)
        host.step(1'b1);
        `CHK(gain_fine, 9'h13d)
        wr(`DGC_CTRL, 16'h0000);
        `CHK(fixed_atten_active, 1'b0)
        `CHK(atten_level, 7'h00)
        `CHK(gain_fine, 9'h13d)
        // every bank select code, curve words read back in internal mode
        wr(`DGC_CTRL, 16'h0010);
        wr(8'h00, 16'hdead);
        wr(`DGC_CTRL, 16'h0030);
        wr(8'h03, 16'hbeef);
        wr(`DGC_CTRL, 16'h0020);
        wr(`DGC_LIMITS_P2, 16'h1e9f);
        host.write_burst(8'h00, '{16'h1111, 16'h2222, 16'h3333});
        wr(`DGC_CTRL, 16'h0029);
        foreach (exp_words[i]) begin
            host.step(1'b0);
            `CHK(curve_word, exp_words[i])
        end
        `CHK(curve_row, 8'h03)
        wr(`DGC_CTRL, 16'h003d);
        host.step(1'b0);
        `CHK(curve_word, 16'hbeef)
        wr(`DGC_CTRL, 16'h0016);
        wr(`DGC_CTRL, 16'h0015);
        host.step(1'b0);
        `CHK(curve_word, 16'hdead)
        `CHK(curve_row, 8'h01)
        wr(`DGC_CTRL, 16'h0002);
        wr(`DGC_CTRL, 16'h0001);
        host.step(1'b0);
        `CHK(curve_word, 16'h4444)
        // unmapped write must not disturb the start gain reload
        wr(8'hbc, 16'hffff);
        wr(`DGC_CTRL, 16'h0000);
        `CHK(gain_fine, 9'h014)
        wr(`DGC_CTRL, 16'h0002);
        wr(`DGC_CTRL, 16'h0008);
        `CHK(gain_fine, 9'h03c)
        // reset in mid-run reloads the profile, control and gain registers and every output; curve banks keep their contents and read data
        rst_b = 1'b0;
        repeat (6) @(posedge clock);
        #1;
        rst_b = 1'b1;
        `CHK(gain_fine, 9'h000)
        `CHK(curve_word, 16'h0000)
        host.step(1'b0);
        `CHK(gain_fine, 9'h001)
        close_out();
    end
endmodule : dgc_engine_tb
